// ===== logic/cantmc_pkg.sv
package cantmc_pkg;
   // transceiver mode encodings, as held in the mode field
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXO  = 2'h2;
   localparam logic [1:0] MODE_NORM = 2'h3;

   // chip-level operating mode, given by the power controller
   typedef enum logic [2:0] {
      SBC_NORMAL,
      SBC_STOP,
      SBC_SLEEP,
      SBC_RESTART,
      SBC_FAILSAFE
   } cantmc_sbc_t;

   ////////////////////////////////////////////////////////////////////
   // register map
   localparam int          ADDR_W    = 8;
   localparam logic [7:0]  OFS_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_STAT  = 8'h04;
   localparam logic [7:0]  OFS_MASK  = 8'h08;
   localparam logic [7:0]  OFS_INFO  = 8'h0c;

   localparam int          STAT_W    = 3;
   localparam int          ST_WAKE   = 0;
   localparam int          ST_TXTO   = 1;
   localparam int          ST_REFUSE = 2;
   localparam int          INF_READY = 0;
   localparam int          INF_ARMED = 1;
   localparam int          INF_WOKEN = 2;
   localparam int          INF_TXTO  = 3;
   localparam int          MODE_LSB  = 0;

   localparam logic [1:0]        CTRL_RST = MODE_OFF;
   localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
   localparam logic [31:0]       ZERO_W   = 32'h0;

   ////////////////////////////////////////////////////////////////////
   // timing
   localparam int CNT_W        = 20;
   typedef logic [CNT_W-1:0] cantmc_cnt_t;
   localparam int CLK_NS       = 20;
   localparam int MAX_BAUD     = 2000000;
   localparam int T_EN_NS      = 20000;
   localparam int T_TXTO_NS    = 1000000;
   localparam int T_WAKE1_NS   = 1000;
   localparam int T_WAKE2_NS   = 1000000;
   // least times round up, longest times round down
   localparam int EN_CYC       = (T_EN_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXTO_CYC     = (T_TXTO_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE1_CYC    = (T_WAKE1_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE2_CYC    = T_WAKE2_NS / CLK_NS;
   localparam cantmc_cnt_t CNT_ONE = 20'h1;
   localparam cantmc_cnt_t CNT_ZERO = 20'h0;
endpackage : cantmc_pkg

// ===== logic/cantmc_wake_det.sv
`timescale 1ns/1ps
module cantmc_wake_det #(
   parameter int WAKE2_CYC = cantmc_pkg::WAKE2_CYC
) (
   input  wire logic clk,       // system clock
   input  wire logic rst_n,     // async reset, active low
   input  wire logic enable,    // detector armed
   input  wire logic bus_dom,   // receiver sees dominant
   output logic      wake       // one-cycle pulse on a full pattern
);
   typedef enum logic [2:0] {W_IDLE, W_DOM1, W_REC, W_DOM2, W_LONG} cantmc_wst_t;
   typedef struct packed {
      cantmc_wst_t         st;
      cantmc_pkg::cantmc_cnt_t cnt;
      logic                wake;
   } cantmc_wdet_t;

   localparam cantmc_pkg::cantmc_cnt_t W1 = cantmc_pkg::cantmc_cnt_t'(cantmc_pkg::WAKE1_CYC);
   localparam cantmc_pkg::cantmc_cnt_t W2 = cantmc_pkg::cantmc_cnt_t'(WAKE2_CYC);

   cantmc_wdet_t s_ff;
   cantmc_wdet_t nxt_s;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s      = s_ff;
      nxt_s.wake = 1'b0;
      nxt_s.cnt  = s_ff.cnt + cantmc_pkg::CNT_ONE;
      case (s_ff.st)
         W_IDLE: begin
            nxt_s.cnt = cantmc_pkg::CNT_ONE;
            if (bus_dom) begin
               nxt_s.st = W_DOM1;
            end
         end
         W_DOM1: begin
            if (!bus_dom) begin
               nxt_s.cnt = cantmc_pkg::CNT_ONE;
               nxt_s.st  = (s_ff.cnt >= W1) ? W_REC : W_IDLE;
            end else if (s_ff.cnt >= W2) begin
               nxt_s.st = W_LONG;
            end
         end
         W_REC: begin
            if (bus_dom) begin
               // too short a gap restarts the first phase
               nxt_s.cnt = cantmc_pkg::CNT_ONE;
               nxt_s.st  = (s_ff.cnt > W1) ? W_DOM2 : W_DOM1;
            end else if (s_ff.cnt >= W2) begin
               nxt_s.st = W_IDLE;
            end
         end
         W_DOM2: begin
            if (!bus_dom) begin
               nxt_s.cnt = cantmc_pkg::CNT_ONE;
               nxt_s.st  = W_IDLE;
            end else if (s_ff.cnt >= W1 - cantmc_pkg::CNT_ONE) begin
               nxt_s.wake = 1'b1;
               nxt_s.st   = W_LONG;
            end
         end
         W_LONG: begin
            // a stuck dominant never counts as a pattern
            nxt_s.cnt = cantmc_pkg::CNT_ONE;
            if (!bus_dom) begin
               nxt_s.st = W_IDLE;
            end
         end
         default: begin
            nxt_s.st = W_IDLE;
         end
      endcase
      if (!enable) begin
         nxt_s.st   = W_IDLE;
         nxt_s.wake = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '{st: W_IDLE, cnt: cantmc_pkg::CNT_ZERO, wake: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign wake = s_ff.wake;
endmodule : cantmc_wake_det

// ===== logic/cantmc_top.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module cantmc_top #(
   parameter int TXTO_CYC  = cantmc_pkg::TXTO_CYC,   // transmit dominant timeout
   parameter int WAKE2_CYC = cantmc_pkg::WAKE2_CYC,  // wake phase upper bound
   parameter int EN_CYC    = cantmc_pkg::EN_CYC      // enable settling length
) (
   input  wire logic        SYS_CLK,      // system clock, 50 MHz
   input  wire logic        RST_N,        // async reset, active low
   input  wire logic        PSEL,         // apb select
   input  wire logic        PENABLE,      // apb access phase
   input  wire logic        PWRITE,       // apb direction
   input  wire logic [7:0]  PADDR,        // apb byte address
   input  wire logic [31:0] PWDATA,       // apb write data
   output logic [31:0]      PRDATA,       // apb read data
   output logic             PREADY,       // apb ready
   output logic             PSLVERR,      // unmapped address
   input  wire logic [2:0]  SBC_MODE,     // chip operating mode
   input  wire logic        TX_DATA_IN,   // transmit input, low = dominant
   input  wire logic        RX_BUS_IN,    // receiver result, low = dominant
   output logic             TX_DRV_DOM,   // drive dominant onto the bus
   output logic             TX_DRV_EN,    // bus driver stage enabled
   output logic             RX_EN,        // receiver enabled
   output logic             RX_DATA_OUT,  // receive output
   output logic             IRQ           // interrupt, active high level
);
   typedef struct packed {
      logic [1:0]                     mode;
      cantmc_pkg::cantmc_cnt_t        en_cnt;
      logic                           armed;
      cantmc_pkg::cantmc_cnt_t        dom_cnt;
      logic                           txto;
      logic                           woken;
      logic [cantmc_pkg::STAT_W-1:0]  stat;
      logic [cantmc_pkg::STAT_W-1:0]  mask;
      logic [31:0]                    rdata;
      logic                           rx_out;
      logic                           drv_dom;
      logic                           irq;
      logic [2:0]                     sbc_prev;
   } cantmc_state_t;

   localparam cantmc_pkg::cantmc_cnt_t EN_LEN   = cantmc_pkg::cantmc_cnt_t'(EN_CYC);
   localparam cantmc_pkg::cantmc_cnt_t TXTO_LEN = cantmc_pkg::cantmc_cnt_t'(TXTO_CYC);

   cantmc_state_t s_ff;
   cantmc_state_t nxt_s;
   logic          wake_evt;
   logic          wr_acc;
   logic          rd_setup;
   logic          mapped;
   logic          mode_ok;
   logic [1:0]    wr_mode;
   logic          in_norm;
   logic          ready;

   ////////////////////////////////////////////////////////////////////
   // wake pattern detector, armed only in Wake Capable before a wake
   cantmc_wake_det #(
      .WAKE2_CYC (WAKE2_CYC)
   ) u_wake (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .enable  (s_ff.mode == cantmc_pkg::MODE_WAKE && !s_ff.woken),
      .bus_dom (!RX_BUS_IN),
      .wake    (wake_evt)
   );

   ////////////////////////////////////////////////////////////////////
   // apb decode; slave never waits
   assign PREADY   = 1'b1;
   assign mapped   = (PADDR == cantmc_pkg::OFS_CTRL) || (PADDR == cantmc_pkg::OFS_STAT) ||
                     (PADDR == cantmc_pkg::OFS_MASK) || (PADDR == cantmc_pkg::OFS_INFO);
   assign PSLVERR  = PSEL && PENABLE && !mapped;
   assign wr_acc   = PSEL && PENABLE && PWRITE && mapped;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign wr_mode  = PWDATA[cantmc_pkg::MODE_LSB +: 2];
   assign in_norm  = s_ff.mode == cantmc_pkg::MODE_NORM;
   assign ready    = s_ff.en_cnt == cantmc_pkg::CNT_ZERO;

   // which mode may be entered from which chip mode
   always_comb begin
      case (wr_mode)
         cantmc_pkg::MODE_OFF:  mode_ok = 1'b1;
         cantmc_pkg::MODE_NORM: mode_ok = SBC_MODE == cantmc_pkg::SBC_NORMAL;
         cantmc_pkg::MODE_RXO:  mode_ok = SBC_MODE == cantmc_pkg::SBC_NORMAL ||
                                          SBC_MODE == cantmc_pkg::SBC_STOP;
         cantmc_pkg::MODE_WAKE: mode_ok = SBC_MODE != cantmc_pkg::SBC_FAILSAFE;
         default:               mode_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s          = s_ff;
      nxt_s.sbc_prev = SBC_MODE;

      // mode field write; refused writes leave the mode and raise a flag
      if (wr_acc && PADDR == cantmc_pkg::OFS_CTRL) begin
         if (mode_ok) begin
            if (wr_mode != s_ff.mode) begin
               nxt_s.woken = 1'b0;                 // toggling the mode rearms
            end
            nxt_s.mode = wr_mode;
            if (wr_mode == cantmc_pkg::MODE_NORM && !in_norm) begin
               nxt_s.en_cnt = EN_LEN;
               nxt_s.armed  = 1'b0;
            end
         end else begin
            nxt_s.stat[cantmc_pkg::ST_REFUSE] = 1'b1;
         end
      end

      // entering a low-power chip mode rearms the wake detector
      if (SBC_MODE != s_ff.sbc_prev && (SBC_MODE == cantmc_pkg::SBC_STOP ||
          SBC_MODE == cantmc_pkg::SBC_SLEEP)) begin
         nxt_s.woken = 1'b0;
      end
      // fail-safe entry falls back to wake capable; off stays writable afterwards
      if (SBC_MODE == cantmc_pkg::SBC_FAILSAFE && s_ff.sbc_prev != cantmc_pkg::SBC_FAILSAFE) begin
         nxt_s.mode  = cantmc_pkg::MODE_WAKE;
         nxt_s.woken = 1'b0;
      end

      // settling countdown; the entry cycle keeps the freshly loaded length
      if (nxt_s.mode != cantmc_pkg::MODE_NORM) begin
         nxt_s.en_cnt = cantmc_pkg::CNT_ZERO;
         nxt_s.armed  = 1'b0;
      end else if (!in_norm) begin
         nxt_s.armed  = 1'b0;
      end else if (!ready) begin
         nxt_s.en_cnt = s_ff.en_cnt - cantmc_pkg::CNT_ONE;
      end else if (TX_DATA_IN) begin
         nxt_s.armed = 1'b1;                       // recessive seen after settling
      end

      // dominant timeout on the transmit input
      if (in_norm && !TX_DATA_IN) begin
         if (s_ff.dom_cnt >= TXTO_LEN) begin
            nxt_s.txto = 1'b1;
         end else begin
            nxt_s.dom_cnt = s_ff.dom_cnt + cantmc_pkg::CNT_ONE;
         end
      end else begin
         nxt_s.dom_cnt = cantmc_pkg::CNT_ZERO;
         nxt_s.txto    = 1'b0;                     // released once input returns high
      end

      // mask and write-one-to-clear status
      if (wr_acc && PADDR == cantmc_pkg::OFS_MASK) begin
         nxt_s.mask = PWDATA[cantmc_pkg::STAT_W-1:0];
      end
      if (wr_acc && PADDR == cantmc_pkg::OFS_STAT) begin
         nxt_s.stat = nxt_s.stat & ~PWDATA[cantmc_pkg::STAT_W-1:0];
      end
      // hardware sets win over a same-cycle clear
      if (wake_evt) begin
         nxt_s.woken                     = 1'b1;
         nxt_s.stat[cantmc_pkg::ST_WAKE] = 1'b1;
      end
      if (nxt_s.txto && !s_ff.txto) begin
         nxt_s.stat[cantmc_pkg::ST_TXTO] = 1'b1;
      end
      nxt_s.irq = |(nxt_s.stat & nxt_s.mask);

      // driver: follows input only when settled, armed and not timed out
      nxt_s.drv_dom = (nxt_s.mode == cantmc_pkg::MODE_NORM) && (nxt_s.en_cnt == cantmc_pkg::CNT_ZERO) &&
                      nxt_s.armed && !nxt_s.txto && !TX_DATA_IN;

      // receive output: one flop of latency keeps 2 Mbaud bits intact
      if (nxt_s.woken) begin
         nxt_s.rx_out = 1'b0;
      end else if (nxt_s.mode == cantmc_pkg::MODE_NORM || nxt_s.mode == cantmc_pkg::MODE_RXO) begin
         nxt_s.rx_out = RX_BUS_IN;
      end else begin
         nxt_s.rx_out = 1'b1;
      end

      // read data is captured in the setup phase
      if (rd_setup) begin
         nxt_s.rdata = cantmc_pkg::ZERO_W;
         case (PADDR)
            cantmc_pkg::OFS_CTRL: nxt_s.rdata[cantmc_pkg::MODE_LSB +: 2] = s_ff.mode;
            cantmc_pkg::OFS_STAT: nxt_s.rdata[cantmc_pkg::STAT_W-1:0] = s_ff.stat;
            cantmc_pkg::OFS_MASK: nxt_s.rdata[cantmc_pkg::STAT_W-1:0] = s_ff.mask;
            cantmc_pkg::OFS_INFO: begin
               nxt_s.rdata[cantmc_pkg::INF_READY] = in_norm && ready;
               nxt_s.rdata[cantmc_pkg::INF_ARMED] = s_ff.armed;
               nxt_s.rdata[cantmc_pkg::INF_WOKEN] = s_ff.woken;
               nxt_s.rdata[cantmc_pkg::INF_TXTO]  = s_ff.txto;
            end
            default: nxt_s.rdata = cantmc_pkg::ZERO_W;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_ff          <= '0;
         s_ff.mode     <= cantmc_pkg::CTRL_RST;
         s_ff.stat     <= cantmc_pkg::STAT_RST;
         s_ff.mask     <= cantmc_pkg::MASK_RST;
         s_ff.rx_out   <= 1'b1;
         s_ff.sbc_prev <= cantmc_pkg::SBC_NORMAL;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign PRDATA      = s_ff.rdata;
   assign TX_DRV_DOM  = s_ff.drv_dom;
   assign TX_DRV_EN   = (s_ff.mode == cantmc_pkg::MODE_NORM) && ready && !s_ff.txto;
   assign RX_EN       = s_ff.mode != cantmc_pkg::MODE_OFF;
   assign RX_DATA_OUT = s_ff.rx_out;
   assign IRQ         = s_ff.irq;
endmodule : cantmc_top

// ===== bench/cantmc_top_props.sv
`timescale 1ns/1ps
module cantmc_top_props #(
   parameter int TXTO_CYC = cantmc_pkg::TXTO_CYC,
   parameter int EN_CYC   = cantmc_pkg::EN_CYC
) (
   input logic        SYS_CLK,     // clock
   input logic        RST_N,       // reset, active low
   input logic        PSEL,        // apb select
   input logic        PENABLE,     // apb access
   input logic        PWRITE,      // apb direction
   input logic [7:0]  PADDR,       // apb address
   input logic [31:0] PWDATA,      // apb write data
   input logic        TX_DATA_IN,  // transmit input
   input logic        RX_BUS_IN,   // receiver result
   input logic        TX_DRV_DOM,  // drive dominant
   input logic        TX_DRV_EN,   // driver enabled
   input logic        RX_EN,       // receiver enabled
   input logic        RX_DATA_OUT  // receive output
);
   logic [15:0] low_ff;
   logic [15:0] nxt_low;
   logic        wr_ctrl;
   assign wr_ctrl = PSEL && PENABLE && PWRITE && PADDR == cantmc_pkg::OFS_CTRL;
   always_comb nxt_low = TX_DATA_IN ? 16'h0 : low_ff + {15'h0, low_ff != 16'hffff};
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) low_ff <= 16'h0;
      else low_ff <= nxt_low;
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   chk_off_quiet: assert property (!RX_EN && !$past(RX_EN) |-> !TX_DRV_EN && !TX_DRV_DOM)
      else $error("driver active while off");
   chk_off_always: assert property (wr_ctrl && PWDATA[1:0] == cantmc_pkg::MODE_OFF |=> !RX_EN)
      else $error("off write not taken");
   chk_off_rx_idle: assert property (!RX_EN && !$past(RX_EN) |-> RX_DATA_OUT)
      else $error("receive output low while off");
   chk_dom_gated: assert property (TX_DRV_DOM |-> $past(TX_DRV_EN))
      else $error("dominant without enabled driver");
   chk_settle_quiet: assert property (wr_ctrl && PWDATA[1:0] == cantmc_pkg::MODE_NORM && !RX_EN
      |=> !TX_DRV_EN [*8]) else $error("driver enabled during settling");
   chk_arm_edge: assert property ($rose(TX_DRV_DOM) |-> $past(TX_DATA_IN, 2))
      else $error("dominant without prior recessive");
   chk_dom_follow: assert property (TX_DRV_DOM |-> !$past(TX_DATA_IN))
      else $error("dominant while input recessive");
   chk_rx_follow: assert property (TX_DRV_EN && $past(TX_DRV_EN) |-> RX_DATA_OUT == $past(RX_BUS_IN))
      else $error("receive output not following bus");
   chk_txto_drop: assert property (low_ff > TXTO_CYC + 1 |-> !TX_DRV_DOM)
      else $error("dominant beyond timeout");
   cover property ($rose(TX_DRV_DOM));
   cover property (low_ff > TXTO_CYC + 1);
   cover property (RX_EN && !TX_DRV_EN && $fell(RX_DATA_OUT));
endmodule : cantmc_top_props
bind cantmc_top cantmc_top_props #(.TXTO_CYC(TXTO_CYC), .EN_CYC(EN_CYC)) u_props (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .TX_DATA_IN(TX_DATA_IN), .RX_BUS_IN(RX_BUS_IN), .TX_DRV_DOM(TX_DRV_DOM),
   .TX_DRV_EN(TX_DRV_EN), .RX_EN(RX_EN), .RX_DATA_OUT(RX_DATA_OUT));

// ===== bench/cantmc_host_model.sv
`timescale 1ns/1ps
module cantmc_host_model (
   input  logic tx_bit,      // bit the protocol controller sends
   input  logic remote_dom,  // another node drives dominant
   input  logic drv_dom,     // device drives dominant
   output logic tx_data_in,  // to transmit input
   output logic rx_bus_in    // receiver result, low = dominant
);
   // recessive through settling unless a scenario breaks it on purpose
   assign tx_data_in = tx_bit;
   // wired bus: any dominant source wins
   assign rx_bus_in = !(drv_dom || remote_dom);
endmodule : cantmc_host_model

// ===== bench/test_can_transceiver_mode_control.sv
`timescale 1ns/1ps
module test_can_transceiver_mode_control;
   localparam int         EN = 20;
   localparam int         TO = 200;
   localparam logic [7:0] A_CTRL = cantmc_pkg::OFS_CTRL;
   localparam logic [7:0] A_STAT = cantmc_pkg::OFS_STAT;
   localparam logic [7:0] A_MASK = cantmc_pkg::OFS_MASK;
   logic        clk, rst_n, psel, penable, pwrite, tx_bit, remote_dom, err;
   logic        pready, pslverr, tx_in, rx_bus, drv_dom, drv_en, rx_en, rx_out, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0]  sbc;
   int          fails, total_checks;
   cantmc_top #(.TXTO_CYC(TO), .WAKE2_CYC(300), .EN_CYC(EN)) dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SBC_MODE(sbc), .TX_DATA_IN(tx_in), .RX_BUS_IN(rx_bus), .TX_DRV_DOM(drv_dom),
      .TX_DRV_EN(drv_en), .RX_EN(rx_en), .RX_DATA_OUT(rx_out), .IRQ(irq));
   cantmc_host_model host (.tx_bit(tx_bit), .remote_dom(remote_dom), .drv_dom(drv_dom),
      .tx_data_in(tx_in), .rx_bus_in(rx_bus));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////
   task t_regs;
      chk({rx_en, drv_en, drv_dom, rx_out, irq}, 5'h2);
      for (int a = 0; a < 16; a += 4) begin
         apb(1'h0, a[7:0], 32'h0);
         chk(q, 32'h0);
      end
      apb(1'h1, 8'h10, 32'hffffffff);
      chk(err, 1'h1);
      apb(1'h0, A_CTRL, 32'h0);
      chk(q, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task t_modes;
      logic ok;
      apb(1'h1, A_MASK, 32'h4);
      for (int s = 0; s < 5; s++) begin
         for (int m = 0; m < 4; m++) begin
            ok = (m == 0) || (m == 1 && s < 4) || (m == 2 && s < 2) || (m == 3 && s == 0);
            apb(1'h1, A_CTRL, 32'h0);
            sbc <= s[2:0];
            apb(1'h1, A_CTRL, m);
            apb(1'h0, A_CTRL, 32'h0);
            chk(q, ok ? m : 0);
            apb(1'h0, A_STAT, 32'h0);
            chk(q, ok ? 0 : 4);
            chk(irq, !ok);
            apb(1'h1, A_STAT, 32'h4);
            cyc(1);
            chk(irq, 1'h0);
         end
      end
      apb(1'h1, A_MASK, 32'h0);
      apb(1'h1, A_CTRL, 32'h3);
      cyc(2);
      chk(irq, 1'h0);
      apb(1'h1, A_STAT, 32'h7);
      $display("test modes done");
   endtask : t_modes
   task t_norm;
      sbc <= 3'h0;
      apb(1'h1, A_CTRL, 32'h3);
      // recessive inside settling must not arm the driver
      cyc(3);
      chk(drv_en, 1'h0);
      tx_bit <= 1'h0;
      repeat (EN + 10) begin
         @(posedge clk);
         chk(drv_dom, 1'h0);
      end
      tx_bit <= 1'h1;
      cyc(3);
      tx_bit <= 1'h0;
      cyc(3);
      chk({drv_dom, rx_out}, 2'h2);
      tx_bit <= 1'h1;
      cyc(3);
      chk({drv_dom, rx_out}, 2'h1);
      tx_bit <= 1'h0;
      cyc(TO + 10);
      chk(drv_dom, 1'h0);
      apb(1'h0, A_STAT, 32'h0);
      chk(q[1], 1'h1);
      apb(1'h0, A_CTRL, 32'h0);
      chk(q, 32'h3);
      tx_bit <= 1'h1;
      cyc(3);
      tx_bit <= 1'h0;
      cyc(3);
      chk(drv_dom, 1'h1);
      tx_bit <= 1'h1;
      cyc(3);
      $display("test normal done");
   endtask : t_norm
   task t_reset;
      rst_n <= 1'h0;
      cyc(2);
      rst_n <= 1'h1;
      cyc(2);
      chk({rx_en, drv_en, drv_dom, rx_out, irq}, 5'h2);
      apb(1'h0, A_CTRL, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_rxonly;
      apb(1'h1, A_CTRL, 32'h2);
      tx_bit <= 1'h0;
      remote_dom <= 1'h1;
      cyc(5);
      chk({drv_en, drv_dom, rx_en, rx_out}, 4'h2);
      tx_bit <= 1'h1;
      remote_dom <= 1'h0;
      cyc(3);
      chk(rx_out, 1'h1);
      $display("test receive only done");
   endtask : t_rxonly
   task wake_pat;
      remote_dom <= 1'h1;
      cyc(80);
      remote_dom <= 1'h0;
      cyc(80);
      remote_dom <= 1'h1;
      cyc(80);
      remote_dom <= 1'h0;
      cyc(3);
   endtask : wake_pat
   task t_wake;
      apb(1'h1, A_CTRL, 32'h0);
      apb(1'h1, A_MASK, 32'h1);
      wake_pat();
      apb(1'h0, A_STAT, 32'h0);
      chk(q, 32'h0);
      chk({rx_out, irq}, 2'h2);
      apb(1'h1, A_CTRL, 32'h1);
      wake_pat();
      cyc(20);
      chk({rx_out, irq}, 2'h1);
      apb(1'h0, A_CTRL, 32'h0);
      chk(q, 32'h1);
      apb(1'h1, A_STAT, 32'h1);
      cyc(1);
      chk(irq, 1'h0);
      apb(1'h1, A_CTRL, 32'h0);
      cyc(2);
      chk(rx_out, 1'h1);
      $display("test wake done");
   endtask : t_wake
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      sbc = 3'h0;
      tx_bit = 1'h1;
      remote_dom = 1'h0;
      fails = 0;
      total_checks = 0;
      cyc(3);
      rst_n <= 1'h1;
      cyc(1);
      t_regs();
      t_modes();
      t_norm();
      t_reset();
      t_rxonly();
      t_wake();
      end_sim();
   end
   initial begin
      cyc(20000);
      fails++;
      end_sim();
   end
endmodule : test_can_transceiver_mode_control
